// file: bench/fpi_panel_model.sv
/*
 Panel partner: buttons, key switch and interlock contacts, all active low.
 Assumes ref_clk from the bench; pins move just after rising edges.
*/
`timescale 1ns/1ps
module fpi_panel_model #(
   parameter int HOLD = 10
) (
   input  wire logic       ref_clk,
   output logic      [8:0] pins_b
);
   // Contacts grounded, loop closed, buttons up, key off
   initial pins_b = 9'h1F0;
   task automatic set_pin(input int idx, input logic v);
      @(posedge ref_clk);
      pins_b[idx] <= v;
   endtask
   // Held past the debounce window, else the press is lost
   task automatic press(input int idx);
      set_pin(idx, 1'b0);
      repeat (HOLD) @(posedge ref_clk);
      pins_b[idx] <= 1'b1;
      repeat (HOLD) @(posedge ref_clk);
   endtask
endmodule

// file: bench/fpi_status_interlock_assertions.sv
/*
 Checker for the panel status block: lamp timing and output trips at its ports.
 Assumes one clock domain; bound into the design by the bind at the foot.
*/
`timescale 1ns/1ps
module fpi_status_interlock_assertions #(
   parameter int DEBOUNCE_CYC   = 4,
   parameter int BLINK_HALF_CYC = 8
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic coolant_flow_ok_input_b,
   input wire logic chamber_pressure_ok_input_b,
   input wire logic spare_interlock_input_b,
   input wire logic remote_stop_loop_input_b,
   input wire logic panic_button_b,
   input wire logic life_counter_zero,
   input wire logic over_temp,
   input wire logic arc_sensed,
   input wire logic at_setpoint,
   input wire logic output_enable,
   input wire logic alarm,
   input wire logic at_target_lamp,
   input wire logic output_lamp,
   input wire logic left_display_lamp,
   input wire logic run_lamp
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Sync flops, debounce window, state update, one spare cycle
   localparam int LIM = DEBOUNCE_CYC + 4;
   logic [4:0]  bad;
   int unsigned open_cnt [5];
   logic        tripped;
   assign bad = {~panic_button_b, remote_stop_loop_input_b, spare_interlock_input_b,
                 chamber_pressure_ok_input_b, coolant_flow_ok_input_b};
   // Counts saturate so a long open never wraps back to zero
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 5; i++) open_cnt[i] <= 0;
      end else begin
         for (int i = 0; i < 5; i++) open_cnt[i] <= !bad[i] ? 0 : (open_cnt[i] > LIM ? open_cnt[i] : open_cnt[i] + 1);
      end
   end
   always_comb begin
      tripped = 1'b0;
      for (int i = 0; i < 5; i++) tripped |= open_cnt[i] > LIM;
   end

   a_left_lamp_lit: assert property ($past(rst_b) |-> left_display_lamp)
      else $error("left display lamp dark");
   a_run_lamp_follow: assert property ($past(rst_b) |-> run_lamp == $past(output_enable))
      else $error("run lamp does not follow output");
   a_out_lamp_follow: assert property ($past(rst_b) |-> output_lamp == $past(output_enable))
      else $error("output lamp does not follow output");
   a_target_lamp_cause: assert property (at_target_lamp |-> $past(output_enable && at_setpoint))
      else $error("at target lamp lit without cause");
   a_alarm_cause: assert property ($past(rst_b) |-> alarm == $past(life_counter_zero || arc_sensed))
      else $error("alarm does not match its causes");
   a_hot_output_off: assert property (over_temp |-> ##[1:2] !output_enable)
      else $error("output stays on while hot");
   a_no_run_hot: assert property ($rose(output_enable) |-> !$past(over_temp))
      else $error("output turned on while hot");
   a_open_trip: assert property (tripped |-> !output_enable)
      else $error("output on with interlock open or panic held");
endmodule

bind fpi_status_interlock fpi_status_interlock_assertions #(
   .DEBOUNCE_CYC(DEBOUNCE_CYC), .BLINK_HALF_CYC(BLINK_HALF_CYC)
) i_fpi_status_interlock_assertions (
   .ref_clk, .rst_b, .coolant_flow_ok_input_b, .chamber_pressure_ok_input_b, .spare_interlock_input_b,
   .remote_stop_loop_input_b, .panic_button_b, .life_counter_zero, .over_temp, .arc_sensed, .at_setpoint,
   .output_enable, .alarm, .at_target_lamp, .output_lamp, .left_display_lamp, .run_lamp);

// file: bench/fpi_status_interlock_tb.sv
/*
 Bench for the panel status block: register master, condition inputs, panel partner.
 Assumes design, checker and panel model compiled first.
*/
`timescale 1ns/1ps
`include "fpi_consts.svh"
module fpi_status_interlock_tb;
   localparam int DEB = 4;
   localparam int BL  = 8;
   localparam logic [1:0] MLAMP [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
   logic        ref_clk, rst_b, reg_wr, reg_rd;
   logic        rd_seen = 1'b0;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, r, ex, exp_q[$];
   logic [8:0]  pins_b;
   logic        life_counter_zero, over_temp, arc_sensed, at_setpoint, output_enable, alarm;
   logic        life_expired_lamp, overheat_lamp, coolant_lamp, chamber_lamp, spare_lamp, arc_lamp;
   logic        at_target_lamp, output_lamp, left_display_lamp, stop_lamp, run_lamp;
   logic        power_reg_lamp, current_reg_lamp;
   int          n_fail = 0;
   int          n_tests = 0;
   fpi_status_interlock #(.DEBOUNCE_CYC(DEB), .BLINK_HALF_CYC(BL)) i_fpi_status_interlock (
      .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .coolant_flow_ok_input_b(pins_b[0]), .chamber_pressure_ok_input_b(pins_b[1]),
      .spare_interlock_input_b(pins_b[2]), .remote_stop_loop_input_b(pins_b[3]),
      .stop_button_b(pins_b[4]), .run_button_b(pins_b[5]), .panic_button_b(pins_b[6]),
      .key_locked_b(pins_b[7]), .key_program_b(pins_b[8]), .life_counter_zero, .over_temp,
      .arc_sensed, .at_setpoint, .output_enable, .alarm, .life_expired_lamp, .overheat_lamp,
      .coolant_lamp, .chamber_lamp, .spare_lamp, .arc_lamp, .at_target_lamp, .output_lamp,
      .left_display_lamp, .stop_lamp, .run_lamp, .power_reg_lamp, .current_reg_lamp);
   fpi_panel_model #(.HOLD(DEB + 6)) i_fpi_panel_model (.ref_clk, .pins_b);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic st(input logic [31:0] e);
      rd(`FPI_OFS_STATUS, e);
   endtask
   task automatic pr(input int i);
      i_fpi_panel_model.press(i);
   endtask
   task automatic sp(input int i, input logic v);
      i_fpi_panel_model.set_pin(i, v);
   endtask
   function automatic logic lamp(input int i);
      case (i)
         0: return coolant_lamp;
         1: return chamber_lamp;
         2: return spare_lamp;
         3: return life_expired_lamp;
         5: return overheat_lamp;
         default: return stop_lamp;
      endcase
   endfunction
   // Flashing lamps must track the stop lamp cycle for cycle
   task automatic watch(input int i, input logic fl);
      int   tg;
      logic pv;
      tg = 0;
      pv = lamp(i);
      repeat (2 * BL + 2) begin
         @(negedge ref_clk);
         if (lamp(i) !== pv) tg++;
         pv = lamp(i);
         if (fl) check(lamp(i), stop_lamp);
      end
      check(tg >= 2, fl);
      if (!fl) check(pv, 1'b1);
   endtask

   // Read data is due the cycle after the strobe
   always @(posedge ref_clk) begin
      if (rd_seen) check(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
   end
   initial begin
      cyc(20000);
      n_fail++;
      summarize();
   end

   initial begin
      {reg_wr, reg_rd, life_counter_zero, over_temp, arc_sensed, at_setpoint} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      rst_b = 1'b0;
      r = $urandom(44);
      cyc(8);
      rst_b <= 1'b1;
      cyc(20);
      @(negedge ref_clk);
      check(left_display_lamp, 1'b1);
      watch(4, 1'b1);
      pr(4);
      st(32'h0);
      watch(4, 1'b0);
      for (int m = 0; m < 4; m++) begin
         wr(`FPI_OFS_CTRL, 32'h18 | (m << 1));
         cyc(2);
         @(negedge ref_clk);
         check({power_reg_lamp, current_reg_lamp}, MLAMP[m]);
      end
      pr(5);
      st(32'h1);
      check({run_lamp, output_lamp, stop_lamp}, 3'b110);
      repeat (4) begin
         @(posedge ref_clk) at_setpoint <= 1'($urandom());
         cyc(2);
         @(negedge ref_clk);
         check(at_target_lamp, at_setpoint);
      end
      @(posedge ref_clk) arc_sensed <= 1'b1;
      cyc(2);
      @(negedge ref_clk);
      check({arc_lamp, alarm}, 2'b11);
      @(posedge ref_clk) arc_sensed <= 1'b0;
      sp(0, 1'b1);
      cyc(r[1]);
      sp(0, 1'b0);
      cyc(DEB + 6);
      st(32'h1);
      @(posedge ref_clk) over_temp <= 1'b1;
      cyc(3);
      pr(5);
      check({output_enable, overheat_lamp}, 2'b01);
      over_temp <= 1'b0;
      pr(5);
      life_counter_zero <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         ex = 32'h2 | (32'h1 << ((k + r) % 3 + 2)) | (32'h1 << ((k + r) % 3 + 5));
         sp((k + r) % 3, 1'b1);
         cyc(DEB + 6);
         st(ex);
         pr(4);
         st(ex);
         watch((k + r) % 3, 1'b1);
         watch(3, 1'b1);
         sp((k + r) % 3, 1'b0);
         cyc(DEB + 6);
         pr(4);
         st(32'h0);
         watch((k + r) % 3, 1'b0);
         pr(5);
      end
      life_counter_zero <= 1'b0;
      sp(3, 1'b1);
      cyc(DEB + 6);
      st(32'h102);
      pr(4);
      st(32'h102);
      sp(3, 1'b0);
      cyc(DEB + 6);
      pr(4);
      st(32'h0);
      pr(5);
      pr(6);
      st(32'h2);
      pr(4);
      st(32'h0);
      for (int j = 7; j < 9; j++) begin
         sp(j, 1'b0);
         cyc(DEB + 6);
         st(32'h2 | (32'h1 << (j + 2)));
         pr(4);
         st(32'h1 << (j + 2));
         sp(j, 1'b1);
         cyc(DEB + 6);
      end
      wr(`FPI_OFS_CTRL, 32'h19);
      wr(`FPI_OFS_CMD, 32'h1);
      st(32'h1);
      wr(`FPI_OFS_CMD, 32'h2);
      st(32'h0);
      wr(`FPI_OFS_CTRL, 32'h18);
      st(32'h2);
      pr(4);
      rd(4'hC, 32'h0);
      rd(`FPI_OFS_CMD, 32'h0);
      wr(`FPI_OFS_STATUS, 32'hFFFFFFFF);
      st(32'h0);
      rd(`FPI_OFS_CTRL, 32'h18);
      // Standard panel, no spare lamp: spare loss must still trip output
      wr(`FPI_OFS_CTRL, 32'h0);
      pr(5);
      st(32'h1);
      sp(2, 1'b1);
      cyc(DEB + 6);
      st(32'h92);
      check(spare_lamp, 1'b0);
      @(posedge ref_clk) over_temp <= 1'b1;
      cyc(2);
      watch(5, 1'b1);
      @(posedge ref_clk) over_temp <= 1'b0;
      sp(2, 1'b0);
      cyc(DEB + 6);
      pr(4);
      st(32'h0);
      sp(8, 1'b0);
      cyc(3);
      rst_b <= 1'b0;
      cyc(8);
      rst_b <= 1'b1;
      cyc(20);
      st(32'h402);
      cyc(3);
      summarize();
   end
endmodule

// file: verilog/fpi_consts.svh
/*
 Constants for the front panel status and interlock block: register offsets,
 field positions, reset values, mode codes and timing figures.
 Assumes a 100 MHz ref_clk and is included by its bare name.
*/
`ifndef FPI_CONSTS_SVH
`define FPI_CONSTS_SVH

`define FPI_CLK_HZ          100000000
`define FPI_DEBOUNCE_US     10000
`define FPI_BLINK_HALF_US   250000
`define FPI_DEBOUNCE_CYC    (`FPI_DEBOUNCE_US * (`FPI_CLK_HZ / 1000000))
`define FPI_BLINK_HALF_CYC  (`FPI_BLINK_HALF_US * (`FPI_CLK_HZ / 1000000))

`define FPI_ADDR_W          4
`define FPI_OFS_CTRL        4'h0
`define FPI_OFS_CMD         4'h4
`define FPI_OFS_STATUS      4'h8

`define FPI_CTRL_HOST       0
`define FPI_CTRL_MODE_LO    1
`define FPI_CTRL_MODE_HI    2
`define FPI_CTRL_PASSIVE    3
`define FPI_CTRL_SPARE_LAMP 4
`define FPI_CTRL_RESET      5'h10

`define FPI_CMD_RUN         0
`define FPI_CMD_STOP        1

`define FPI_MODE_POWER      2'h0
`define FPI_MODE_CURRENT    2'h1
`define FPI_MODE_VOLTAGE    2'h2

`define FPI_IN_COOLANT      0
`define FPI_IN_CHAMBER      1
`define FPI_IN_SPARE        2
`define FPI_IN_LOOP         3
`define FPI_IN_STOP         4
`define FPI_IN_RUN          5
`define FPI_IN_PANIC        6
`define FPI_IN_KEY_LOCK     7
`define FPI_IN_KEY_PROGRAM_KEYPOSITION     8
`define FPI_N_IN            9

`endif

// file: verilog/fpi_pkg.sv
/*
 Types for the front panel status and interlock block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fpi_pkg;
   typedef enum logic [1:0] {
      FPI_SETTLE,
      FPI_CHECK,
      FPI_ACTIVE
   } fpi_start_t;
endpackage

// file: verilog/fpi_status_interlock.sv
/*
 Front panel status and interlock logic: debounces panel pins, keeps the
 output on/off and reset-required state, drives steady and flashing lamps.
 Assumes one 100 MHz clock, active-low pins that read low when grounded or
 pressed, and condition inputs from logic on the same clock.
*/
`timescale 1ns/1ps
`include "fpi_consts.svh"

// What this block does
// - Flash life-expired lamp and sound alarm when target-life counter reaches zero.
// - Overtemperature switches output off and flashes the overheat lamp, lit steady on a passive panel.
// - Interlock lamp lit steadily when input grounded and unit reset by stop.
// - Opened interlock ground turns output off and flashes that input's lamp.
// - Spare interlock loss turns output off even without its lamp fitted.
// - Passive panel arc lamp lights whenever an arc is sensed.
// - Passive at-target lamp lit only while output on and at setpoint.
// - Passive output lamp lit whenever output is on.
// - Left display-select lamp always lit.
// - Stop lamp steady while output off, flashing while reset required.
// - Power-up with key in program or locked sets reset-required.
// - Control returning from host to panel sets reset-required.
// - Key moving from off to locked or program sets reset-required.
// - Open remote stop loop sets reset-required.
// - Unmet interlock or panic press sets reset-required.
// - Stop press clears reset-required, leaving the stop lamp steady.
// - Stop reset ignored while stop loop open or any interlock unmet.
// - Run lamp lit whenever output is on.
// - Power mode lights power lamp only; current mode lights current lamp only.
// - Voltage mode lights both power and current lamps.
module fpi_status_interlock #(
   parameter int DEBOUNCE_CYC   = `FPI_DEBOUNCE_CYC,
   parameter int BLINK_HALF_CYC = `FPI_BLINK_HALF_CYC
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_b,
   input  wire logic [`FPI_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [31:0]            reg_rdata,
   input  wire logic                   coolant_flow_ok_input_b,
   input  wire logic                   chamber_pressure_ok_input_b,
   input  wire logic                   spare_interlock_input_b,
   input  wire logic                   remote_stop_loop_input_b,
   input  wire logic                   stop_button_b,
   input  wire logic                   run_button_b,
   input  wire logic                   panic_button_b,
   input  wire logic                   key_locked_b,
   input  wire logic                   key_program_b,
   input  wire logic                   life_counter_zero,
   input  wire logic                   over_temp,
   input  wire logic                   arc_sensed,
   input  wire logic                   at_setpoint,
   output logic                        output_enable,
   output logic                        alarm,
   output logic                        life_expired_lamp,
   output logic                        overheat_lamp,
   output logic                        coolant_lamp,
   output logic                        chamber_lamp,
   output logic                        spare_lamp,
   output logic                        arc_lamp,
   output logic                        at_target_lamp,
   output logic                        output_lamp,
   output logic                        left_display_lamp,
   output logic                        stop_lamp,
   output logic                        run_lamp,
   output logic                        power_reg_lamp,
   output logic                        current_reg_lamp
);

   localparam int DW = $clog2(DEBOUNCE_CYC + 1);
   localparam int BW = $clog2(BLINK_HALF_CYC + 1);
   localparam int N  = `FPI_N_IN;

   logic [N-1:0]  pin_raw;
   logic [N-1:0]  meta_ff;
   logic [N-1:0]  sync_ff;
   logic [N-1:0]  deb_ff;
   logic [N-1:0]  deb_prev_ff;
   logic [N-1:0]  active;
   logic [N-1:0]  pressed;
   logic [BW-1:0] blink_cnt_ff;
   logic          blink_ff;
   logic [DW:0]   settle_cnt_ff;
   fpi_pkg::fpi_start_t start_ff;
   logic [4:0]    ctrl_ff;
   logic          host_cmd_run;
   logic          host_cmd_stop;
   logic          host_prev_ff;
   logic          out_on_ff;
   logic          reset_req_ff;
   logic [2:0]    fault_ff;
   logic [2:0]    ilk_open;
   logic          loop_open;
   logic          key_on;
   logic          key_on_prev_ff;
   logic          running;
   logic          set_req;
   logic          reset_ok;
   logic          trip;
   logic          run_req;
   logic          stop_req;

   assign pin_raw = {key_program_b, key_locked_b, panic_button_b, run_button_b, stop_button_b,
                     remote_stop_loop_input_b, spare_interlock_input_b,
                     chamber_pressure_ok_input_b, coolant_flow_ok_input_b};

   // Each pin: two-stage sync, then must hold steady for the debounce time
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_in
         logic [DW-1:0] cnt_ff;
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_ff[gi] <= 1'b1;
               sync_ff[gi] <= 1'b1;
            end else begin
               meta_ff[gi] <= pin_raw[gi];
               sync_ff[gi] <= meta_ff[gi];
            end
         end
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               cnt_ff     <= '0;
               deb_ff[gi] <= 1'b1;
            end else if (sync_ff[gi] == deb_ff[gi]) begin
               cnt_ff <= '0;
            end else if (cnt_ff == DW'(DEBOUNCE_CYC - 1)) begin
               cnt_ff     <= '0;
               deb_ff[gi] <= sync_ff[gi];
            end else begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         deb_prev_ff <= '1;
      end else begin
         deb_prev_ff <= deb_ff;
      end
   end

   assign active  = ~deb_ff;
   assign pressed = deb_prev_ff & ~deb_ff;

   // Shared blink source keeps all flashing lamps in phase
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         blink_cnt_ff <= '0;
         blink_ff     <= 1'b0;
      end else if (blink_cnt_ff == BW'(BLINK_HALF_CYC - 1)) begin
         blink_cnt_ff <= '0;
         blink_ff     <= ~blink_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 1'b1;
      end
   end

   // Level-triggered sets are held off until the debouncers have settled
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         settle_cnt_ff <= '0;
         start_ff      <= fpi_pkg::FPI_SETTLE;
      end else begin
         case (start_ff)
            fpi_pkg::FPI_SETTLE: begin
               settle_cnt_ff <= settle_cnt_ff + 1'b1;
               if (settle_cnt_ff == (DW+1)'(2 * DEBOUNCE_CYC)) begin
                  start_ff <= fpi_pkg::FPI_CHECK;
               end
            end
            fpi_pkg::FPI_CHECK:  start_ff <= fpi_pkg::FPI_ACTIVE;
            fpi_pkg::FPI_ACTIVE: start_ff <= fpi_pkg::FPI_ACTIVE;
            default:             start_ff <= fpi_pkg::FPI_SETTLE;
         endcase
      end
   end

   assign running = (start_ff == fpi_pkg::FPI_ACTIVE);

   // Register port
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= `FPI_CTRL_RESET;
      end else if (reg_wr && reg_addr == `FPI_OFS_CTRL) begin
         ctrl_ff <= reg_wdata[4:0];
      end
   end

   assign host_cmd_run  = reg_wr && reg_addr == `FPI_OFS_CMD && reg_wdata[`FPI_CMD_RUN];
   assign host_cmd_stop = reg_wr && reg_addr == `FPI_OFS_CMD && reg_wdata[`FPI_CMD_STOP];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `FPI_OFS_CTRL:   reg_rdata <= {27'h0, ctrl_ff};
            `FPI_OFS_STATUS: reg_rdata <= {21'h0, active[`FPI_IN_KEY_PROGRAM_KEYPOSITION:`FPI_IN_KEY_LOCK],
                                           loop_open, ilk_open, fault_ff, reset_req_ff, out_on_ff};
            default:         reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   assign ilk_open  = deb_ff[`FPI_IN_SPARE:`FPI_IN_COOLANT];
   assign loop_open = deb_ff[`FPI_IN_LOOP];
   assign key_on    = active[`FPI_IN_KEY_LOCK] | active[`FPI_IN_KEY_PROGRAM_KEYPOSITION];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_prev_ff   <= 1'b0;
         key_on_prev_ff <= 1'b0;
      end else begin
         host_prev_ff   <= ctrl_ff[`FPI_CTRL_HOST];
         key_on_prev_ff <= key_on;
      end
   end

   always_comb begin
      set_req = 1'b0;
      if (start_ff == fpi_pkg::FPI_CHECK && key_on) begin
         set_req = 1'b1;
      end
      if (host_prev_ff && !ctrl_ff[`FPI_CTRL_HOST]) begin
         set_req = 1'b1;
      end
      if (running && key_on && !key_on_prev_ff) begin
         set_req = 1'b1;
      end
      if (running && loop_open) begin
         set_req = 1'b1;
      end
      if (running && (|ilk_open || pressed[`FPI_IN_PANIC])) begin
         set_req = 1'b1;
      end
   end

   // A stop press only resets with the loop closed and all interlocks made
   assign reset_ok = pressed[`FPI_IN_STOP] && !loop_open && !(|ilk_open);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reset_req_ff <= 1'b1;
      end else if (set_req) begin
         reset_req_ff <= 1'b1;
      end else if (reset_ok) begin
         reset_req_ff <= 1'b0;
      end
   end

   // Per-interlock latched fault; set wins over the reset press
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_ff <= 3'h0;
      end else begin
         fault_ff <= (fault_ff & ~{3{reset_ok}}) | (ilk_open & {3{running}});
      end
   end

   assign trip = over_temp || (|ilk_open) || loop_open || active[`FPI_IN_PANIC]
                 || reset_req_ff || !running;
   assign run_req  = ctrl_ff[`FPI_CTRL_HOST] ? host_cmd_run : pressed[`FPI_IN_RUN];
   assign stop_req = pressed[`FPI_IN_STOP] || host_cmd_stop;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_on_ff <= 1'b0;
      end else if (trip || stop_req) begin
         out_on_ff <= 1'b0;
      end else if (run_req) begin
         out_on_ff <= 1'b1;
      end
   end

   assign output_enable = out_on_ff;

   // Lamps from flip-flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         life_expired_lamp <= 1'b0;
         alarm             <= 1'b0;
         overheat_lamp     <= 1'b0;
         arc_lamp          <= 1'b0;
      end else begin
         life_expired_lamp <= life_counter_zero & blink_ff;
         alarm             <= life_counter_zero | arc_sensed;
         overheat_lamp     <= over_temp & (ctrl_ff[`FPI_CTRL_PASSIVE] | blink_ff);
         arc_lamp          <= arc_sensed;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         coolant_lamp <= 1'b0;
         chamber_lamp <= 1'b0;
         spare_lamp   <= 1'b0;
      end else begin
         coolant_lamp <= fault_ff[0] ? blink_ff : (!ilk_open[0] && !reset_req_ff);
         chamber_lamp <= fault_ff[1] ? blink_ff : (!ilk_open[1] && !reset_req_ff);
         spare_lamp   <= ctrl_ff[`FPI_CTRL_SPARE_LAMP]
                         && (fault_ff[2] ? blink_ff : (!ilk_open[2] && !reset_req_ff));
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         at_target_lamp    <= 1'b0;
         output_lamp       <= 1'b0;
         left_display_lamp <= 1'b0;
         stop_lamp         <= 1'b0;
         run_lamp          <= 1'b0;
      end else begin
         at_target_lamp    <= out_on_ff & at_setpoint;
         output_lamp       <= out_on_ff;
         left_display_lamp <= 1'b1;
         stop_lamp         <= reset_req_ff ? blink_ff : !out_on_ff;
         run_lamp          <= out_on_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         power_reg_lamp   <= 1'b0;
         current_reg_lamp <= 1'b0;
      end else begin
         case (ctrl_ff[`FPI_CTRL_MODE_HI:`FPI_CTRL_MODE_LO])
            `FPI_MODE_POWER: begin
               power_reg_lamp   <= 1'b1;
               current_reg_lamp <= 1'b0;
            end
            `FPI_MODE_CURRENT: begin
               power_reg_lamp   <= 1'b0;
               current_reg_lamp <= 1'b1;
            end
            `FPI_MODE_VOLTAGE: begin
               power_reg_lamp   <= 1'b1;
               current_reg_lamp <= 1'b1;
            end
            default: begin
               power_reg_lamp   <= 1'b0;
               current_reg_lamp <= 1'b0;
            end
         endcase
      end
   end

endmodule
